// File: hdl/ldd_display_driver.sv
`timescale 1ns/100ps
// Function
// [R1] type select set gives push-pull LED drive
// [R2] LED common and segment polarity chosen independently
// [R3] LED off holds lines at inactive level
// [R4] LED duty static, 1/4, 1/8, 1/12, 1/16
// [R5] LED frame rate between 55 and 75 Hz
// [R6] bias bit selects three or four levels
// [R7] half bias never uses the third level
// [R8] two bias resistor select bits
// [R9] capacitor biasing enables the charge pump
// [R10] enable low stops drive, display blank
// [R11] both enables clear at power-on
// [R12] software initialises display memory after power-up
// [R13] scan clock is sub clock divided eight
// [R14] type select clear gives LCD drive
// [R15] type bit picks LCD scheme A or B
// [R16] sleep holds the driver reset and off
// [R17] commons in equal slots, segments from memory
module ldd_display_driver (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sub_clock,
	input wire logic sleep_mode,
	input wire logic cap_bias_cfg,
	input wire logic [1:0] pump_ratio_cfg,
	input wire logic [ldd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ldd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [ldd_pkg::DATA_W-1:0] reg_rdata,
	output logic [ldd_pkg::NUM_COM*ldd_pkg::LVL_W-1:0] backplane_line,
	output logic [ldd_pkg::NUM_SEG*ldd_pkg::LVL_W-1:0] segment_line,
	output logic push_pull_mode,
	output logic charge_pump_en,
	output logic [1:0] pump_ratio,
	output logic [1:0] bias_resistor_sel,
	output logic bias_third
);

	// ----------------------------------------------------------------
	// registers and display memory
	// ----------------------------------------------------------------
	logic [7:0] panel_control_reg_q, panel_control_reg_d;
	logic [7:0] matrix_control_reg_q, matrix_control_reg_d;
	logic [ldd_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic [ldd_pkg::DATA_W-1:0] status_word;
	// no reset on the memory: software is expected to fill it first
	logic [ldd_pkg::NUM_SEG-1:0] dmem [0:ldd_pkg::NUM_COM-1];

	logic [ldd_pkg::SLOT_W-1:0] slot_q, slot_d;
	logic [ldd_pkg::TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic phase_q, phase_d;
	logic scan_tick;

	logic led_mode, active, bias3, type_b, com_pol, seg_pol;
	logic [ldd_pkg::SLOT_W-1:0] ncom_m1;
	logic [ldd_pkg::TICK_W-1:0] slot_len_m1;
	ldd_pkg::ldd_led_duty_t led_duty;

	logic [ldd_pkg::NUM_COM*ldd_pkg::LVL_W-1:0] bp_q, bp_d;
	logic [ldd_pkg::NUM_SEG*ldd_pkg::LVL_W-1:0] sg_q, sg_d;
	logic pp_q, pp_d, pump_q, pump_d, bias3_q, bias3_d;
	logic [1:0] ratio_q, ratio_d, rsel_q, rsel_d;

	ldd_scan_div u_div (
		.core_clk(core_clk),
		.rst(rst),
		.sub_clock(sub_clock),
		.scan_tick(scan_tick)
	);

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	assign led_mode = matrix_control_reg_q[ldd_pkg::MTX_SEL_BIT]; // [R1] [R14]
	assign bias3 = panel_control_reg_q[ldd_pkg::PNL_BIAS_BIT]; // [R6]
	assign type_b = panel_control_reg_q[ldd_pkg::PNL_TYPE_BIT]; // [R15]
	assign com_pol = matrix_control_reg_q[ldd_pkg::MTX_COMPOL_BIT]; // [R2]
	assign seg_pol = matrix_control_reg_q[ldd_pkg::MTX_SEGPOL_BIT]; // [R2]
	assign led_duty = ldd_pkg::ldd_led_duty_t'(matrix_control_reg_q[ldd_pkg::MTX_DUTY_LSB +: 3]);

	// sleep overrides both enables, acting as the driver's reset
	assign active = !sleep_mode && (led_mode ? // [R16]
		matrix_control_reg_q[ldd_pkg::MTX_EN_BIT] :
		panel_control_reg_q[ldd_pkg::PNL_EN_BIT]); // [R10]

	// commons in use and ticks per slot; 1/12 rounds down to a 60 tick frame
	always_comb begin
		ncom_m1 = 4'h3;
		slot_len_m1 = ldd_pkg::LED_SLOT16_M1;
		if (led_mode) begin
			unique case (led_duty) // [R4] [R5]
				ldd_pkg::LDD_LED_STATIC: begin
					ncom_m1 = 4'h0;
					slot_len_m1 = ldd_pkg::LED_SLOT1_M1;
				end
				ldd_pkg::LDD_LED_D4: begin
					ncom_m1 = 4'h3;
					slot_len_m1 = ldd_pkg::LED_SLOT4_M1;
				end
				ldd_pkg::LDD_LED_D8: begin
					ncom_m1 = 4'h7;
					slot_len_m1 = ldd_pkg::LED_SLOT8_M1;
				end
				ldd_pkg::LDD_LED_D12: begin
					ncom_m1 = 4'hB;
					slot_len_m1 = ldd_pkg::LED_SLOT12_M1;
				end
				default: begin
					ncom_m1 = 4'hF;
					slot_len_m1 = ldd_pkg::LED_SLOT16_M1;
				end
			endcase
		end else begin
			unique case (panel_control_reg_q[ldd_pkg::PNL_DUTY_LSB +: 2])
				ldd_pkg::LCD_DUTY_2: ncom_m1 = 4'h1;
				ldd_pkg::LCD_DUTY_3: ncom_m1 = 4'h2;
				default: ncom_m1 = 4'h3;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	always_comb begin
		status_word = '0;
		status_word[ldd_pkg::STS_ACTIVE_BIT] = active;
		status_word[ldd_pkg::STS_PHASE_BIT] = phase_q;
		status_word[ldd_pkg::STS_SLOT_LSB +: ldd_pkg::SLOT_W] = slot_q;
	end

	// writes update control, reads answer one cycle later, unmapped reads zero
	always_comb begin
		panel_control_reg_d = panel_control_reg_q;
		matrix_control_reg_d = matrix_control_reg_q;
		rdata_d = '0;
		if (reg_we && reg_addr == ldd_pkg::PANEL_CTRL_ADDR) begin
			panel_control_reg_d = reg_wdata[7:0];
		end
		if (reg_we && reg_addr == ldd_pkg::MATRIX_CTRL_ADDR) begin
			matrix_control_reg_d = reg_wdata[7:0];
		end
		if (reg_re) begin
			if (reg_addr[ldd_pkg::DMEM_SEL_BIT]) begin
				rdata_d = dmem[reg_addr[ldd_pkg::SLOT_W-1:0]];
			end else if (reg_addr == ldd_pkg::PANEL_CTRL_ADDR) begin
				rdata_d = {8'h00, panel_control_reg_q};
			end else if (reg_addr == ldd_pkg::MATRIX_CTRL_ADDR) begin
				rdata_d = {8'h00, matrix_control_reg_q};
			end else if (reg_addr == ldd_pkg::STATUS_ADDR) begin
				rdata_d = status_word;
			end
		end
	end

	// display memory is a plain write port, scanned live by the output logic
	always_ff @(posedge core_clk) begin
		if (reg_we && reg_addr[ldd_pkg::DMEM_SEL_BIT]) begin
			dmem[reg_addr[ldd_pkg::SLOT_W-1:0]] <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// scan sequencer
	// ----------------------------------------------------------------
	// led: fixed ticks per slot; lcd type a flips phase every tick,
	// type b flips once per frame for a lower drive frequency
	always_comb begin
		slot_d = slot_q;
		tick_cnt_d = tick_cnt_q;
		phase_d = phase_q;
		if (!active) begin
			slot_d = '0; // [R10] [R16]
			tick_cnt_d = '0;
			phase_d = 1'b0;
		end else if (scan_tick) begin
			if (led_mode) begin
				if (tick_cnt_q >= slot_len_m1) begin
					tick_cnt_d = '0;
					slot_d = (slot_q >= ncom_m1) ? '0 : slot_q + 1'b1; // [R17]
				end else begin
					tick_cnt_d = tick_cnt_q + 1'b1;
				end
			end else if (!type_b) begin
				phase_d = !phase_q; // [R15]
				if (phase_q) begin
					slot_d = (slot_q >= ncom_m1) ? '0 : slot_q + 1'b1; // [R17]
				end
			end else begin
				slot_d = (slot_q >= ncom_m1) ? '0 : slot_q + 1'b1;
				if (slot_q >= ncom_m1) begin
					phase_d = !phase_q; // [R15]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// line waveforms
	// ----------------------------------------------------------------
	always_comb begin
		bp_d = '0;
		sg_d = '0;
		for (int i = 0; i < ldd_pkg::NUM_COM; i++) begin
			if (led_mode) begin
				// off or not in slot: opposite of the chosen active level
				bp_d[i*ldd_pkg::LVL_W +: ldd_pkg::LVL_W] =
					((active && slot_q == i[ldd_pkg::SLOT_W-1:0]) ~^ !com_pol) ?
					ldd_pkg::LVL_VSS : ldd_pkg::LVL_VA; // [R2] [R3] [R17]
			end else if (active) begin
				if (slot_q == i[ldd_pkg::SLOT_W-1:0]) begin
					bp_d[i*ldd_pkg::LVL_W +: ldd_pkg::LVL_W] =
						phase_q ? ldd_pkg::LVL_VSS : ldd_pkg::LVL_VA;
				end else begin
					bp_d[i*ldd_pkg::LVL_W +: ldd_pkg::LVL_W] = (bias3 && !phase_q) ?
						ldd_pkg::LVL_VC : ldd_pkg::LVL_VB; // [R6] [R7]
				end
			end
		end
		for (int j = 0; j < ldd_pkg::NUM_SEG; j++) begin
			if (led_mode) begin
				sg_d[j*ldd_pkg::LVL_W +: ldd_pkg::LVL_W] =
					((active && dmem[slot_q][j]) ~^ !seg_pol) ?
					ldd_pkg::LVL_VSS : ldd_pkg::LVL_VA; // [R2] [R3] [R17]
			end else if (active) begin
				if (dmem[slot_q][j]) begin
					sg_d[j*ldd_pkg::LVL_W +: ldd_pkg::LVL_W] =
						phase_q ? ldd_pkg::LVL_VA : ldd_pkg::LVL_VSS; // [R17]
				end else if (bias3) begin
					sg_d[j*ldd_pkg::LVL_W +: ldd_pkg::LVL_W] =
						phase_q ? ldd_pkg::LVL_VC : ldd_pkg::LVL_VB; // [R6]
				end else begin
					sg_d[j*ldd_pkg::LVL_W +: ldd_pkg::LVL_W] =
						phase_q ? ldd_pkg::LVL_VSS : ldd_pkg::LVL_VA; // [R7]
				end
			end
		end
		pp_d = led_mode; // [R1] [R14]
		pump_d = cap_bias_cfg; // [R9]
		ratio_d = pump_ratio_cfg; // [R9]
		rsel_d = {panel_control_reg_q[ldd_pkg::PNL_RSEL1_BIT],
			panel_control_reg_q[ldd_pkg::PNL_BIAS_RESISTOR_SEL0_BIT]}; // [R8]
		bias3_d = bias3; // [R6]
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			panel_control_reg_q <= ldd_pkg::PANEL_CTRL_RST; // [R11]
			matrix_control_reg_q <= ldd_pkg::MATRIX_CTRL_RST; // [R11]
			rdata_q <= '0;
			slot_q <= '0;
			tick_cnt_q <= '0;
			phase_q <= 1'b0;
			bp_q <= '0;
			sg_q <= '0;
			pp_q <= 1'b0;
			pump_q <= 1'b0;
			ratio_q <= '0;
			rsel_q <= '0;
			bias3_q <= 1'b0;
		end else begin
			panel_control_reg_q <= panel_control_reg_d;
			matrix_control_reg_q <= matrix_control_reg_d;
			rdata_q <= rdata_d;
			slot_q <= slot_d;
			tick_cnt_q <= tick_cnt_d;
			phase_q <= phase_d;
			bp_q <= bp_d;
			sg_q <= sg_d;
			pp_q <= pp_d;
			pump_q <= pump_d;
			ratio_q <= ratio_d;
			rsel_q <= rsel_d;
			bias3_q <= bias3_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign backplane_line = bp_q;
	assign segment_line = sg_q;
	assign push_pull_mode = pp_q;
	assign charge_pump_en = pump_q;
	assign pump_ratio = ratio_q;
	assign bias_resistor_sel = rsel_q;
	assign bias_third = bias3_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_mode_to_pins: assert property (@(posedge core_clk) disable iff (rst) // [R1]
		push_pull_mode == $past(led_mode))
		else $error("push-pull mode does not follow type select");
	chk_led_off_level: assert property (@(posedge core_clk) disable iff (rst) // [R3]
		(led_mode && !active) |=> (backplane_line[1:0] ==
		($past(com_pol) ? ldd_pkg::LVL_VSS : ldd_pkg::LVL_VA)) &&
		(segment_line[1:0] == ($past(seg_pol) ? ldd_pkg::LVL_VSS : ldd_pkg::LVL_VA)))
		else $error("led line not at inactive level while off");
	chk_lcd_blank: assert property (@(posedge core_clk) disable iff (rst) // [R10]
		(!led_mode && !active) |=> (backplane_line == '0) && (segment_line == '0))
		else $error("lcd lines driven while disabled");
	chk_half_bias: assert property (@(posedge core_clk) disable iff (rst) // [R7]
		(!led_mode && !bias3) |=> (backplane_line[1:0] != ldd_pkg::LVL_VC) &&
		(segment_line[1:0] != ldd_pkg::LVL_VC))
		else $error("third level used under half bias");
	chk_sleep_reset: assert property (@(posedge core_clk) disable iff (rst) // [R16]
		sleep_mode |=> (slot_q == '0) && !phase_q && (tick_cnt_q == '0))
		else $error("scan kept running in sleep");
	chk_enable_reset: assert property (@(posedge core_clk) // [R11]
		$fell(rst) |-> !panel_control_reg_q[ldd_pkg::PNL_EN_BIT] &&
		!matrix_control_reg_q[ldd_pkg::MTX_EN_BIT])
		else $error("enable set right after reset");
	chk_slot_bound: assert property (@(posedge core_clk) disable iff (rst) // [R4]
		(active && $stable(matrix_control_reg_q) && $stable(panel_control_reg_q) &&
		$past(slot_q) <= ncom_m1) |-> slot_q <= ncom_m1)
		else $error("scan slot beyond the commons in use");
	chk_com_select: assert property (@(posedge core_clk) disable iff (rst) // [R2]
		(led_mode && active && slot_q == '0) |=>
		backplane_line[1:0] == ($past(com_pol) ? ldd_pkg::LVL_VA : ldd_pkg::LVL_VSS))
		else $error("active common not at its selected level");

	chk_pump_cfg: assert property (@(posedge core_clk) disable iff (rst) // [R9]
		charge_pump_en == $past(cap_bias_cfg))
		else $error("charge pump enable does not follow bias type");

	chk_bias_levels: assert property (@(posedge core_clk) disable iff (rst) // [R6]
		##1 bias_third == $past(bias3) && bias_resistor_sel == $past(rsel_d))
		else $error("bias outputs do not follow control");

	cov_led_sixteen: cover property (@(posedge core_clk) disable iff (rst)
		led_mode && active && slot_q == 4'hF);
	cov_lcd_type_b: cover property (@(posedge core_clk) disable iff (rst)
		!led_mode && active && type_b && $rose(phase_q));
	cov_sleep_while_on: cover property (@(posedge core_clk) disable iff (rst)
		$rose(sleep_mode) && matrix_control_reg_q[ldd_pkg::MTX_EN_BIT]);

endmodule

// File: hdl/ldd_pkg.sv
package ldd_pkg;

	// ----------------------------------------------------------------
	// geometry and bus
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int NUM_COM = 16;
	localparam int NUM_SEG = 16;
	localparam int LVL_W = 2;
	localparam int SLOT_W = 4;
	localparam int TICK_W = 6;
	localparam int DIV_W = 3;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] PANEL_CTRL_ADDR = 5'h00;
	localparam logic [ADDR_W-1:0] MATRIX_CTRL_ADDR = 5'h01;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 5'h02;
	localparam int DMEM_SEL_BIT = 4;
	localparam logic [7:0] PANEL_CTRL_RST = 8'h00;
	localparam logic [7:0] MATRIX_CTRL_RST = 8'h00;

	// panel_control_reg fields
	localparam int PNL_EN_BIT = 0;
	localparam int PNL_BIAS_BIT = 1;
	localparam int PNL_TYPE_BIT = 2;
	localparam int PNL_BIAS_RESISTOR_SEL0_BIT = 3;
	localparam int PNL_RSEL1_BIT = 4;
	localparam int PNL_DUTY_LSB = 5;

	// matrix_control_reg fields
	localparam int MTX_EN_BIT = 0;
	localparam int MTX_SEL_BIT = 1;
	localparam int MTX_COMPOL_BIT = 2;
	localparam int MTX_SEGPOL_BIT = 3;
	localparam int MTX_DUTY_LSB = 4;

	// status fields
	localparam int STS_ACTIVE_BIT = 0;
	localparam int STS_PHASE_BIT = 1;
	localparam int STS_SLOT_LSB = 4;

	// ----------------------------------------------------------------
	// drive level codes and duty selections
	// ----------------------------------------------------------------
	localparam logic [LVL_W-1:0] LVL_VSS = 2'h0;
	localparam logic [LVL_W-1:0] LVL_VC = 2'h1;
	localparam logic [LVL_W-1:0] LVL_VB = 2'h2;
	localparam logic [LVL_W-1:0] LVL_VA = 2'h3;

	typedef enum logic [2:0] {
		LDD_LED_STATIC,
		LDD_LED_D4,
		LDD_LED_D8,
		LDD_LED_D12,
		LDD_LED_D16
	} ldd_led_duty_t;

	localparam logic [1:0] LCD_DUTY_2 = 2'h0;
	localparam logic [1:0] LCD_DUTY_3 = 2'h1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SUB_DIV = 8;
	localparam int SUB_CLOCK_HZ = 32768;
	localparam int SCAN_HZ = SUB_CLOCK_HZ / SUB_DIV;
	localparam int LED_FRAME_HZ = 64;
	localparam int LED_FRAME_TICKS = SCAN_HZ / LED_FRAME_HZ;
	localparam logic [DIV_W-1:0] SUB_DIV_M1 = DIV_W'(SUB_DIV - 1);
	localparam logic [TICK_W-1:0] LED_SLOT1_M1 = TICK_W'(LED_FRAME_TICKS / 1 - 1);
	localparam logic [TICK_W-1:0] LED_SLOT4_M1 = TICK_W'(LED_FRAME_TICKS / 4 - 1);
	localparam logic [TICK_W-1:0] LED_SLOT8_M1 = TICK_W'(LED_FRAME_TICKS / 8 - 1);
	localparam logic [TICK_W-1:0] LED_SLOT12_M1 = TICK_W'(LED_FRAME_TICKS / 12 - 1);
	localparam logic [TICK_W-1:0] LED_SLOT16_M1 = TICK_W'(LED_FRAME_TICKS / 16 - 1);

endpackage

// File: hdl/ldd_scan_div.sv
`timescale 1ns/100ps
module ldd_scan_div (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sub_clock,
	output logic scan_tick
);

	// ----------------------------------------------------------------
	// sub clock divider
	// ----------------------------------------------------------------
	logic sub_prev_q, sub_prev_d;
	logic [ldd_pkg::DIV_W-1:0] cnt_q, cnt_d;
	logic tick_q, tick_d;

	// count rising edges of the sampled sub clock, one tick per eight
	always_comb begin
		sub_prev_d = sub_clock;
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (sub_clock && !sub_prev_q) begin
			if (cnt_q == ldd_pkg::SUB_DIV_M1) begin
				cnt_d = '0;
				tick_d = 1'b1; // [R13]
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sub_prev_q <= 1'b0;
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			sub_prev_q <= sub_prev_d;
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign scan_tick = tick_q;

	// eight sub clock edges take at least sixteen core cycles
	chk_tick_spacing: assert property (@(posedge core_clk) disable iff (rst) // [R13]
		tick_q |=> !tick_q [*8])
		else $error("scan tick came too soon after the previous one");

endmodule

// File: tb/ldd_panel_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// panel or matrix seen from its pins
// ----------------------------------------
module ldd_panel_model (
	input wire logic core_clk,
	input wire logic clear,
	input wire logic [31:0] backplane_line,
	input wire logic [31:0] segment_line,
	input wire logic push_pull_mode,
	input wire logic com_high,
	input wire logic seg_high,
	output int act_com,
	output logic [15:0] seg_bits,
	output int slot_cycles,
	output int frame_cycles,
	output int errs,
	output logic [3:0] lvl_mask,
	output int max_run
);
	int idx, nact, run, fcnt, lrun;
	logic [1:0] c0_q;
	// decode lit commons and segments; clear masks reconfig glitches
	always @(posedge core_clk) begin
		nact = 0;
		idx = -1;
		for (int i = 0; i < 16; i++) begin
			seg_bits[i] = (segment_line[2*i+:2] == ldd_pkg::LVL_VA) == seg_high;
			if ((backplane_line[2*i+:2] == ldd_pkg::LVL_VA) == com_high) begin
				nact++;
				idx = i;
			end
			if (!clear) begin
				lvl_mask[segment_line[2*i+:2]] = 1'b1;
				lvl_mask[backplane_line[2*i+:2]] = 1'b1;
			end
		end
		if (clear) begin
			act_com = -1;
			fcnt = -1;
			lrun = 0;
			max_run = 0;
			lvl_mask = 4'h0;
			slot_cycles = 0;
			frame_cycles = 0;
		end else if (push_pull_mode) begin
			// one common at a time, each the next or a wrap to zero
			if (nact > 1)
				errs++;
			if (idx != act_com) begin
				if (act_com >= 0 && idx >= 0 && idx != act_com + 1 && idx != 0)
					errs++;
				slot_cycles = run;
				run = 0;
				if (idx == 0) begin
					if (fcnt > 0)
						frame_cycles = fcnt;
					fcnt = 0;
				end
			end
			act_com = idx;
			run++;
			if (fcnt >= 0)
				fcnt++;
		end else begin
			// longest steady stretch on common 0 tells the scheme apart
			if (backplane_line[1:0] != c0_q) begin
				if (lrun > max_run)
					max_run = lrun;
				lrun = 0;
			end
			c0_q = backplane_line[1:0];
			lrun++;
		end
	end
endmodule

// File: tb/lcd_led_display_driver_tb.sv
`timescale 1ns/100ps
module lcd_led_display_driver_tb;
	localparam int SUBP = 4;
	localparam int CEIL = 60000;
	logic core_clk = 1'b0, rst = 1'b1, sub_clock = 1'b0, sleep_mode = 1'b0;
	logic cap_bias_cfg = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
	logic clear = 1'b1, com_high = 1'b0, seg_high = 1'b0;
	logic [1:0] pump_ratio_cfg = 2'h0, sub_q = 2'h0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata, seg_bits;
	logic [31:0] backplane_line, segment_line;
	logic push_pull_mode, charge_pump_en, bias_third;
	logic [1:0] pump_ratio, bias_resistor_sel;
	logic [3:0] lvl_mask;
	int act_com, slot_cycles, frame_cycles, errs, max_run, n, e;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	int nt[5] = '{1, 4, 8, 12, 16};

	ldd_display_driver ldd_display_driver_i (
		.core_clk(core_clk), .rst(rst), .sub_clock(sub_clock),
		.sleep_mode(sleep_mode), .cap_bias_cfg(cap_bias_cfg),
		.pump_ratio_cfg(pump_ratio_cfg), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .backplane_line(backplane_line),
		.segment_line(segment_line), .push_pull_mode(push_pull_mode),
		.charge_pump_en(charge_pump_en), .pump_ratio(pump_ratio),
		.bias_resistor_sel(bias_resistor_sel), .bias_third(bias_third)
	);
	ldd_panel_model ldd_panel_model_i (
		.core_clk(core_clk), .clear(clear), .backplane_line(backplane_line),
		.segment_line(segment_line), .push_pull_mode(push_pull_mode),
		.com_high(com_high), .seg_high(seg_high), .act_com(act_com),
		.seg_bits(seg_bits), .slot_cycles(slot_cycles),
		.frame_cycles(frame_cycles), .errs(errs), .lvl_mask(lvl_mask),
		.max_run(max_run)
	);

	// ----------------------------------------
	// clocks and watchdog
	// ----------------------------------------
	always #5 core_clk = ~core_clk;
	// sub clock at a quarter rate keeps a full scan short
	always @(posedge core_clk) begin
		sub_q <= sub_q + 2'h1;
		sub_clock <= sub_q[1];
		cyc <= cyc + 1;
		if (cyc == CEIL) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			summarize();
		end
	end

	// ----------------------------------------
	// compare, bus and setup tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk_val(logic [31:0] got, logic [31:0] exp, string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_num(int got, int exp, string what);
		checks++;
		if (got != exp) begin
			fail_count++;
			$display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	task automatic wr(logic [4:0] a, logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge core_clk);
		reg_we <= 1'b0;
	endtask
	task automatic rd_chk(logic [4:0] a, logic [15:0] exp, string what);
		@(posedge core_clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge core_clk);
		reg_re <= 1'b0;
		#1;
		chk_val(32'(reg_rdata), 32'(exp), what);
	endtask
	function automatic logic [31:0] idle(logic hi);
		return {16{hi ? ldd_pkg::LVL_VSS : ldd_pkg::LVL_VA}};
	endfunction
	function automatic logic [15:0] pat(int k);
		return 16'(16'h8421 ^ (k * 16'h0F35));
	endfunction
	// model is blinded while polarity and mode settle
	task automatic led(logic [15:0] v);
		@(posedge core_clk);
		clear <= 1'b1;
		com_high <= v[ldd_pkg::MTX_COMPOL_BIT];
		seg_high <= v[ldd_pkg::MTX_SEGPOL_BIT];
		wr(ldd_pkg::MATRIX_CTRL_ADDR, v);
		repeat (4) @(posedge core_clk);
		clear <= 1'b0;
		#1;
	endtask
	task automatic lcd(logic [15:0] v, logic [3:0] mask, int run);
		wr(ldd_pkg::PANEL_CTRL_ADDR, v);
		repeat (250) @(posedge core_clk);
		clear <= 1'b1;
		@(posedge core_clk);
		clear <= 1'b0;
		repeat (600) @(posedge core_clk);
		#1;
		chk_val(32'(lvl_mask), 32'(mask), "levels");
		if (run > 0)
			chk_num(max_run, run, "com0 run");
	endtask
	task automatic wait_com(int k);
		for (int i = 0; i < 3000 && act_com != k; i++) begin
			@(posedge core_clk);
			#1;
		end
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk(ldd_pkg::PANEL_CTRL_ADDR, 16'h0000, "panel rst");
		rd_chk(ldd_pkg::MATRIX_CTRL_ADDR, 16'h0000, "matrix rst");
		chk_val(backplane_line | segment_line, 32'h0, "blank");
		wr(5'h05, 16'hFFFF);
		rd_chk(5'h05, 16'h0000, "unmapped");
		rd_chk(ldd_pkg::STATUS_ADDR, 16'h0000, "status off");
		$display("test reset done");
		cap_bias_cfg <= 1'b1;
		pump_ratio_cfg <= 2'h2;
		wr(ldd_pkg::PANEL_CTRL_ADDR, 16'h0012);
		rd_chk(ldd_pkg::PANEL_CTRL_ADDR, 16'h0012, "panel rd");
		chk_val(32'({charge_pump_en, pump_ratio, bias_resistor_sel, bias_third}), 32'h35, "cfg");
		cap_bias_cfg <= 1'b0;
		wr(ldd_pkg::PANEL_CTRL_ADDR, 16'h0008);
		repeat (2) @(posedge core_clk);
		#1;
		chk_val(32'({charge_pump_en, pump_ratio, bias_resistor_sel, bias_third}), 32'h12, "cfg2");
		$display("test config done");
		for (int k = 0; k < 16; k++)
			wr(5'(16 + k), pat(k));
		for (int p = 0; p < 4; p++) begin
			led(16'(2 | (p << 2)));
			chk_val(backplane_line, idle(com_high), "com off");
			chk_val(segment_line, idle(seg_high), "seg off");
			chk_num(push_pull_mode, 1, "push pull");
		end
		$display("test led off done");
		for (int d = 0; d < 5; d++) begin
			n = nt[d];
			led(16'(3 | ((d & 3) << 2) | (d << 4)));
			repeat (6400) @(posedge core_clk);
			#1;
			e = (ldd_pkg::LED_FRAME_TICKS / n) * ldd_pkg::SUB_DIV * SUBP;
			if (n > 1) begin
				chk_num(slot_cycles, e, "slot");
				chk_num(frame_cycles, e * n, "frame");
				chk_num(int'(frame_cycles * 55 <= ldd_pkg::SUB_CLOCK_HZ * SUBP &&
					frame_cycles * 75 >= ldd_pkg::SUB_CLOCK_HZ * SUBP), 1, "rate");
			end
			wait_com(n - 1);
			chk_num(act_com, n - 1, "last com");
			chk_val(32'(seg_bits), 32'(pat(n - 1)), "seg data");
		end
		$display("test led scan done");
		sleep_mode <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk_val(backplane_line, idle(1'b0), "sleep com");
		chk_val(segment_line, idle(1'b0), "sleep seg");
		rd_chk(ldd_pkg::STATUS_ADDR, 16'h0000, "sleep status");
		sleep_mode <= 1'b0;
		rd_chk(ldd_pkg::MATRIX_CTRL_ADDR, 16'h0043, "kept");
		$display("test sleep done");
		led(16'h0000);
		chk_val(32'(push_pull_mode), 32'h0, "lcd mode");
		lcd(16'h0021, 4'hD, 128);
		lcd(16'h0025, 4'hD, 64);
		// half duty and quarter duty panels so 1/2, 1/3 and 1/4 duty are all scanned
		lcd(16'h0001, 4'hD, 64);
		lcd(16'h0043, 4'hF, 0);
		wr(ldd_pkg::PANEL_CTRL_ADDR, 16'h0022);
		repeat (3) @(posedge core_clk);
		#1;
		chk_val(backplane_line | segment_line, 32'h0, "lcd off");
		chk_num(errs, 0, "scan order");
		$display("test lcd done");
		summarize();
	end
endmodule
